// [src/cdm_clock_mgr.sv]
// Module: decoder clock manager with synthesizer, PLL, DSP divider and clock output scaler
//
// Behaviour
// [R1] The reference frequency defaults to 18.432 MHz and may be reprogrammed.
// [R2] Software writes the nominal reference frequency when a different reference is fitted.
// [R3] A synthesizer clocked from the reference produces the internal clock edges; the NCO runs from pclk at PCLK_HZ and never reads ref_freq_khz.
// [R4] Bit 1 of the IO main control cell selects demand (0) or broadcast (1) reception.
// [R5] The synthesizer rate follows the sample rate of the stream being decoded.
// [R6] In broadcast mode a PLL trims the synthesizer to the incoming sample strobes.
// [R7] In demand mode the PLL is off and the device requests data on its demand pin.
// [R8] The DSP clock enable comes from its own programmable divider of the synth clock.
// [R9] The clock output pin runs from the synth clock only while DSP or codec is enabled.
// [R10] The output scaler divides by 1, 2 or 4 by sample rate, with a bypass bit and an extra halving bit.
`timescale 1ns/1ps
module cdm_clock_mgr
	import cdm_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Decoder side
	input wire logic [3:0] stream_fs,
	input wire logic need_data,
	input wire logic sample_strobe,
	// Clock outputs
	output logic synth_tick,
	output logic dsp_clk_en,
	output logic clock_output_pin,
	output logic data_demand_pin_n
);
	logic [1:0] func_ctrl;
	logic broadcast;
	logic scaler_off;
	logic extra_div2;
	logic [31:0] ref_freq_khz;
	logic [7:0] dsp_div;
	logic [NCO_W-1:0] nco_acc;
	logic [NCO_W-1:0] nco_base;
	logic [NCO_W:0] nco_sum;
	logic signed [15:0] trim;
	logic [15:0] edge_count;
	logic [15:0] edge_expect;
	logic pll_lock;
	logic out_en;
	logic [7:0] out_ratio;
	logic [31:0] next_rdata;
	logic wr_access;
	cdm_div_if dsp_if ();
	cdm_div_if out_if ();

	assign wr_access = psel && penable && pwrite;

	// Function enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			func_ctrl <= 2'h0;
		end else if (wr_access && paddr == OFS_FUNC_CTRL) begin
			func_ctrl <= {pwdata[FLD_CODEC_EN], pwdata[FLD_DSP_EN]};
		end
	end

	// Reception mode select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			broadcast <= 1'b0;
		end else if (wr_access && paddr == OFS_IO_MAIN) begin
			broadcast <= pwdata[FLD_BROADCAST]; // R4
		end
	end

	// Output clock config, writable only while the DSP runs; kept when it stops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scaler_off <= 1'b0;
			extra_div2 <= 1'b0;
		end else if (wr_access && paddr == OFS_OUT_CLK_CFG && func_ctrl[FLD_DSP_EN]) begin
			scaler_off <= pwdata[FLD_SCALER_OFF]; // R10
			extra_div2 <= pwdata[FLD_EXTRA_DIV2]; // R10
		end
	end

	// Nominal reference frequency in kHz
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_freq_khz <= RST_REF_FREQ_KHZ; // R1
		end else if (wr_access && paddr == OFS_REF_FREQ) begin
			ref_freq_khz <= pwdata; // R2
		end
	end

	// DSP clock division, set by software to the lowest workable rate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dsp_div <= RST_DSP_DIV;
		end else if (wr_access && paddr == OFS_DSP_DIV) begin
			dsp_div <= pwdata[7:0]; // R8
		end
	end

	// Read data captured in the setup phase, so it comes from flops
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (paddr == OFS_FUNC_CTRL) begin
			next_rdata[1:0] = func_ctrl;
		end else if (paddr == OFS_IO_MAIN) begin
			next_rdata[FLD_BROADCAST] = broadcast;
		end else if (paddr == OFS_OUT_CLK_CFG) begin
			next_rdata[FLD_SCALER_OFF] = scaler_off;
			next_rdata[FLD_EXTRA_DIV2] = extra_div2;
		end else if (paddr == OFS_REF_FREQ) begin
			next_rdata = ref_freq_khz;
		end else if (paddr == OFS_DSP_DIV) begin
			next_rdata[7:0] = dsp_div;
		end else if (paddr == OFS_STATUS) begin
			next_rdata[3:0] = stream_fs;
			next_rdata[FLD_ST_LOCK] = pll_lock;
			next_rdata[FLD_ST_DEMAND] = !data_demand_pin_n;
			next_rdata[FLD_ST_TRIM +: 16] = trim;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			prdata <= pwrite ? 32'h0000_0000 : next_rdata;
			pslverr <= paddr > OFS_STATUS || paddr[1:0] != 2'h0 || (pwrite && paddr == OFS_STATUS);
		end
	end

	assign pready = 1'b1;

	// Synthesizer rate picked by sample rate family, trimmed by the PLL
	always_comb begin
		nco_base = (stream_fs == 4'(CDM_FS_44K1) || stream_fs == 4'(CDM_FS_22K05) || stream_fs == 4'(CDM_FS_11K025))
			? NCO_INC_44K : NCO_INC_48K; // R5
		nco_sum = {1'b0, nco_acc} + {1'b0, nco_base} + (NCO_W+1)'(signed'(trim)); // R3
	end

	// NCO accumulator, carry gives one synth edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nco_acc <= '0;
			synth_tick <= 1'b0;
		end else begin
			nco_acc <= nco_sum[NCO_W-1:0]; // R3
			synth_tick <= nco_sum[NCO_W];
		end
	end

	// Synth edges counted between incoming sample strobes
	assign edge_expect = cdm_edges_per_sample(stream_fs);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edge_count <= 16'h0000;
		end else if (sample_strobe) begin
			edge_count <= {15'h0000, synth_tick};
		end else if (synth_tick && edge_count != 16'hFFFF) begin
			edge_count <= edge_count + 16'h0001;
		end
	end

	// PLL loop: speed up when too few edges per sample, slow down when too many
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trim <= 16'sh0000;
			pll_lock <= 1'b0;
		end else if (!broadcast) begin
			trim <= 16'sh0000; // R7
			pll_lock <= 1'b0;
		end else if (sample_strobe) begin
			if (edge_count < edge_expect && trim != 16'sh7FFF) begin
				trim <= trim + 16'sh0001; // R6
			end else if (edge_count > edge_expect && trim != 16'sh8000) begin
				trim <= trim - 16'sh0001; // R6
			end
			pll_lock <= (edge_count > edge_expect ? edge_count - edge_expect : edge_expect - edge_count) <= PLL_LOCK_TOL;
		end
	end

	// Demand pin asks the host for data only in demand mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_demand_pin_n <= 1'b1;
		end else begin
			data_demand_pin_n <= !(need_data && !broadcast); // R7
		end
	end

	// DSP clock divider
	assign dsp_if.tick_in = synth_tick;
	assign dsp_if.ratio = dsp_div; // R8
	assign dsp_clk_en = dsp_if.tick_out;

	cdm_pulse_div u_dsp_div (
		.pclk(pclk),
		.presetn(presetn),
		.div(dsp_if)
	);

	// Clock output scaler
	always_comb begin
		out_en = func_ctrl[FLD_DSP_EN] || func_ctrl[FLD_CODEC_EN]; // R9
		if (scaler_off) begin
			out_ratio = 8'h01; // R10
		end else begin
			out_ratio = cdm_scaler(stream_fs) << extra_div2; // R10
		end
	end

	assign out_if.tick_in = synth_tick && out_en;
	assign out_if.ratio = out_ratio;

	cdm_pulse_div u_out_div (
		.pclk(pclk),
		.presetn(presetn),
		.div(out_if)
	);

	// Output pin toggles per scaled edge, held low while both functions are off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_output_pin <= 1'b0;
		end else if (!out_en) begin
			clock_output_pin <= 1'b0;
		end else if (out_if.tick_out) begin
			clock_output_pin <= !clock_output_pin; // R9
		end
	end
endmodule : cdm_clock_mgr

// [src/cdm_pkg.sv]
// Package: register map, field positions, reset values and rate tables of the clock manager
package cdm_pkg;
	// Clock and synthesizer rates
	localparam longint PCLK_HZ = 100000000;
	localparam longint SYNTH_48K_HZ = 24576000; // Synth clock for 48/32 kHz families
	localparam longint SYNTH_44K_HZ = 22579200; // Synth clock for 44.1 kHz family
	localparam int NCO_W = 32;
	// NCO carries twice per synth period, one per output edge
	localparam logic [NCO_W-1:0] NCO_INC_48K = NCO_W'((64'd2 * 64'(SYNTH_48K_HZ) << NCO_W) / 64'(PCLK_HZ));
	localparam logic [NCO_W-1:0] NCO_INC_44K = NCO_W'((64'd2 * 64'(SYNTH_44K_HZ) << NCO_W) / 64'(PCLK_HZ));
	// Register byte offsets
	localparam logic [7:0] OFS_FUNC_CTRL = 8'h00;
	localparam logic [7:0] OFS_IO_MAIN = 8'h04;
	localparam logic [7:0] OFS_OUT_CLK_CFG = 8'h08;
	localparam logic [7:0] OFS_REF_FREQ = 8'h0C;
	localparam logic [7:0] OFS_DSP_DIV = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	// Field positions
	localparam int FLD_DSP_EN = 0;
	localparam int FLD_CODEC_EN = 1;
	localparam int FLD_BROADCAST = 1;
	localparam int FLD_SCALER_OFF = 8;
	localparam int FLD_EXTRA_DIV2 = 17;
	localparam int FLD_ST_LOCK = 4;
	localparam int FLD_ST_DEMAND = 5;
	localparam int FLD_ST_TRIM = 8;
	// Reset values
	localparam logic [31:0] RST_REF_FREQ_KHZ = 32'h0000_4800; // 18432 kHz nominal
	localparam logic [7:0] RST_DSP_DIV = 8'h04;
	localparam logic [15:0] PLL_LOCK_TOL = 16'h0004;
	// Sample rate codes
	typedef enum logic [3:0] {
		CDM_FS_48K, CDM_FS_44K1, CDM_FS_32K, CDM_FS_24K, CDM_FS_22K05,
		CDM_FS_16K, CDM_FS_12K, CDM_FS_11K025, CDM_FS_8K
	} cdm_fs_t;
	// Scaler division for the clock output, by sample rate
	function automatic logic [7:0] cdm_scaler(input logic [3:0] fs);
		logic [7:0] r;
		r = 8'h01;
		if (fs >= 4'h6) begin
			r = 8'h04;
		end else if (fs >= 4'h3) begin
			r = 8'h02;
		end
		return r;
	endfunction : cdm_scaler
	// Synth edges expected between two sample strobes of the incoming stream
	function automatic logic [15:0] cdm_edges_per_sample(input logic [3:0] fs);
		logic [15:0] r;
		r = 16'h0400; // 512 synth periods, two edges each
		if (fs == 4'h2) begin
			r = 16'h0600;
		end else if (fs == 4'h5) begin
			r = 16'h0C00;
		end else if (fs == 4'h8) begin
			r = 16'h1800;
		end else if (fs >= 4'h6) begin
			r = 16'h1000;
		end else if (fs >= 4'h3) begin
			r = 16'h0800;
		end
		return r;
	endfunction : cdm_edges_per_sample
endpackage : cdm_pkg

// [src/cdm_div_if.sv]
// Interface: enable pulse divider request and result
`timescale 1ns/1ps
interface cdm_div_if;
	logic tick_in;
	logic [7:0] ratio;
	logic tick_out;
	modport owner (output tick_in, output ratio, input tick_out);
	modport divider (input tick_in, input ratio, output tick_out);
endinterface : cdm_div_if

// [src/cdm_pulse_div.sv]
// Module: divides a stream of enable pulses by a programmable ratio
`timescale 1ns/1ps
module cdm_pulse_div
	import cdm_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Divider port
	cdm_div_if.divider div
);
	logic [7:0] count;

	// Count input pulses, emit one pulse per ratio; ratio 0 acts as 1
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= 8'h00;
		end else if (div.tick_in) begin
			if (count + 8'h01 >= div.ratio) begin
				count <= 8'h00;
			end else begin
				count <= count + 8'h01;
			end
		end
	end

	assign div.tick_out = div.tick_in && (count + 8'h01 >= div.ratio);
endmodule : cdm_pulse_div

// [testbench/cdm_clock_mgr_asserts.sv]
// Checker: port assertions for the decoder clock manager
`timescale 1ns/1ps
module cdm_clock_mgr_asserts
	import cdm_pkg::*;
(
	// Clock, reset and register bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Decoder side and clock outputs
	input wire logic need_data,
	input wire logic synth_tick,
	input wire logic dsp_clk_en,
	input wire logic clock_output_pin,
	input wire logic data_demand_pin_n
);
	logic bcast;
	logic [1:0] fen;
	logic [3:0] up;
	logic [7:0] ddiv;
	// Shadow of reception mode, function enables and DSP ratio, age since reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bcast <= 1'b0;
			fen <= 2'h0;
			up <= 4'h0;
			ddiv <= RST_DSP_DIV;
		end else begin
			if (psel && penable && pwrite && paddr == OFS_DSP_DIV) begin
				ddiv <= pwdata[7:0];
			end
			if (psel && penable && pwrite && paddr == OFS_IO_MAIN) begin
				bcast <= pwdata[FLD_BROADCAST];
			end
			if (psel && penable && pwrite && paddr == OFS_FUNC_CTRL) begin
				fen <= pwdata[1:0];
			end
			if (up != 4'hF) begin
				up <= up + 4'h1;
			end
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_demand_pin_low: assert property (!bcast && need_data |=> !data_demand_pin_n)
		else $error("demand pin not asserted");
	a_demand_pin_idle: assert property (!need_data || bcast |=> data_demand_pin_n)
		else $error("demand pin asserted without cause");
	a_tick_single: assert property (synth_tick |=> !synth_tick)
		else $error("synth tick longer than one cycle");
	a_tick_rate: assert property (up == 4'hF && !synth_tick ##1 !synth_tick |=> synth_tick)
		else $error("synth tick rate too low");
	a_dsp_single: assert property (dsp_clk_en |=> !dsp_clk_en)
		else $error("dsp enable longer than one cycle");
	a_dsp_spacing: assert property (dsp_clk_en && up == 4'hF && ddiv >= 8'h03 |=> !dsp_clk_en [*5])
		else $error("dsp enable too frequent");
	a_clkout_off: assert property (fen == 2'h0 |=> !clock_output_pin)
		else $error("clock output runs while disabled");
	a_unmapped_err: assert property (psel && !penable && paddr > OFS_STATUS |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_status_quiet: assert property (psel && !penable && paddr == OFS_STATUS && !bcast && !$past(bcast)
		|=> !prdata[FLD_ST_LOCK] && prdata[23:8] == 16'h0)
		else $error("pll active in demand mode");
endmodule : cdm_clock_mgr_asserts

bind cdm_clock_mgr cdm_clock_mgr_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .need_data, .synth_tick, .dsp_clk_en, .clock_output_pin, .data_demand_pin_n);

// [testbench/cdm_host_model.sv]
// Partner model: host controller feeding compressed data
`timescale 1ns/1ps
module cdm_host_model #(
	parameter int PERIOD = 2000
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Device side
	input wire logic bcast,
	input wire logic data_demand_pin_n,
	output logic sample_strobe,
	output logic [15:0] words
);
	logic [15:0] cnt;
	// Send a word only while the device demands one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			words <= 16'h0;
		end else if (!bcast && !data_demand_pin_n) begin
			words <= words + 16'h1;
		end
	end
	// One strobe per sample of the broadcast stream
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 16'h0;
			sample_strobe <= 1'b0;
		end else begin
			cnt <= (cnt == 16'(PERIOD - 1)) ? 16'h0 : cnt + 16'h1;
			sample_strobe <= bcast && cnt == 16'h0;
		end
	end
endmodule : cdm_host_model

// [testbench/cdm_clock_mgr_test.sv]
// Testbench: clock manager with host model
`timescale 1ns/1ps
module cdm_clock_mgr_test
	import cdm_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, need_data, bcast, pready, pslverr, err;
	logic synth_tick, dsp_clk_en, clock_output_pin, data_demand_pin_n, sample_strobe;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] stream_fs;
	logic [15:0] words, w0;
	int fails, comparisons, ticks, dsps, togs;
	int tab [7][4] = '{'{1, 0, 0, 1}, '{1, 4, 0, 2}, '{1, 7, 0, 4}, '{1, 7, 256, 1}, '{1, 3, 131072, 4},
		'{1, 8, 131328, 1}, '{2, 6, 0, 4}};
	cdm_clock_mgr uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.stream_fs, .need_data, .sample_strobe, .synth_tick, .dsp_clk_en, .clock_output_pin, .data_demand_pin_n);
	cdm_host_model host (.pclk, .presetn, .bcast, .data_demand_pin_n, .sample_strobe, .words);
	// Clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// One bus transfer, result in rd and err
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic near(input int got, input int exp, input int tol);
		comparisons++;
		if (got > exp + tol || got < exp - tol) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : near
	// Count ticks, dsp pulses and pin toggles over n cycles
	task automatic measure(input int n);
		logic last;
		ticks = 0;
		dsps = 0;
		togs = 0;
		// Settle off the edge first, so a toggle launched at the calling edge is not counted
		@(posedge pclk);
		#1;
		last = clock_output_pin;
		repeat (n) begin
			@(posedge pclk);
			#1;
			ticks += int'(synth_tick === 1'b1);
			dsps += int'(dsp_clk_en === 1'b1);
			togs += int'(clock_output_pin !== last);
			last = clock_output_pin;
		end
	endtask : measure
	task automatic t_regs();
		logic [31:0] rst [5];
		rst = '{32'h0, 32'h0, 32'h0, RST_REF_FREQ_KHZ, 32'(RST_DSP_DIV)};
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			chk(rd, rst[i]);
		end
		apb(1'b1, OFS_REF_FREQ, 32'h0000_3000);
		apb(1'b0, OFS_REF_FREQ, 32'h0);
		chk(rd, 32'h0000_3000);
		apb(1'b0, 8'h18, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		apb(1'b1, OFS_STATUS, 32'hFF);
		chk(32'(err), 32'h1);
		stream_fs <= 4'h2;
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(32'(rd[3:0]), 32'h2);
	endtask : t_regs
	task automatic t_demand();
		need_data <= 1'b1;
		repeat (2) @(posedge pclk);
		#1;
		chk(32'(data_demand_pin_n), 32'h0);
		chk(32'(words != 16'h0), 32'h1);
		apb(1'b1, OFS_IO_MAIN, 32'h2);
		bcast <= 1'b1;
		repeat (2) @(posedge pclk);
		w0 = words;
		repeat (5) @(posedge pclk);
		#1;
		chk(32'(data_demand_pin_n), 32'h1);
		chk(32'(words), 32'(w0));
	endtask : t_demand
	task automatic t_pll();
		repeat (7000) @(posedge pclk);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(32'(rd[FLD_ST_TRIM+:16] != 16'h0), 32'h1);
		apb(1'b1, OFS_IO_MAIN, 32'h0);
		bcast <= 1'b0;
		repeat (3) @(posedge pclk);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk({rd[23:8], 11'h0, rd[FLD_ST_LOCK]}, 32'h0);
	endtask : t_pll
	task automatic t_outclk();
		apb(1'b1, OFS_OUT_CLK_CFG, 32'h100);
		apb(1'b0, OFS_OUT_CLK_CFG, 32'h0);
		chk(rd, 32'h0);
		measure(300);
		chk(32'(togs), 32'h0);
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, OFS_FUNC_CTRL, 32'h1);
			apb(1'b1, OFS_OUT_CLK_CFG, 32'(tab[i][2]));
			apb(1'b1, OFS_FUNC_CTRL, 32'(tab[i][0]));
			stream_fs <= 4'(tab[i][1]);
			repeat (20) @(posedge pclk);
			measure(400);
			near(togs * tab[i][3], ticks, tab[i][3] + 1);
			near(ticks, int'(2 * ((tab[i][1] % 3 == 1) ? SYNTH_44K_HZ : SYNTH_48K_HZ) * 400 / PCLK_HZ), 3);
		end
	endtask : t_outclk
	task automatic t_dsp();
		apb(1'b1, OFS_FUNC_CTRL, 32'h1);
		measure(800);
		near(dsps * 4, ticks, 8);
		apb(1'b1, OFS_DSP_DIV, 32'h8);
		apb(1'b0, OFS_DSP_DIV, 32'h0);
		chk(rd, 32'h8);
		measure(800);
		near(dsps * 8, ticks, 16);
	endtask : t_dsp
	task automatic print_verdict();
		if (fails == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict
	// Watchdog
	initial begin
		#500000;
		fails++;
		print_verdict();
	end
	// Main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		stream_fs = 4'h0;
		need_data = 1'b0;
		bcast = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_demand();
		t_pll();
		t_outclk();
		t_dsp();
		print_verdict();
	end
endmodule : cdm_clock_mgr_test
